// >>> logic/drpd_top.sv
// Overview of operation
// - with a permit terminal assigned, run commands are accepted only while permit is on
// - a terminal whose function code is 13 is the run-permit input
// - permit mode 0 always grants; mode 1 follows the terminal; default 1
// - permit-loss action 0..2: coast, quick stop, quick stop with resume; default coast
// - coast: output is blocked at once when permit drops
// - quick stop: ramp down over quick-stop time; restart needs a fresh run edge
// - quick stop resume: ramp down, then restart once permit and run are on again
// - quick-stop time 0.0..600.0 s, default 5.0 s, used only by quick stops
// - run: ramp to accel dwell frequency, hold for dwell time, then normal accel
// - stop: ramp to decel dwell frequency, hold for dwell time, then ramp to stop
// - accel dwell freq clamped start..max, default 5.00 Hz; time 0..10.0 s
// - decel dwell freq clamped start..max, default 5.00 Hz; time up to 60.0 s
// - a dwell is skipped if its time or frequency is zero
// - only the first acceleration after each start from idle dwells, including a quick stop resume restart
// - decel dwell only on stop passing the dwell freq, not on ref change or ext brake
// - dwell is available with the volts-per-hertz control mode, code 0
`timescale 1ns/100ps
`include "drpd_consts.svh"
module drpd_top #(
   parameter int MS_CYCLES = `DRPD_MS_TICK_NS / `DRPD_CLK_PERIOD_NS
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_run_cmd,
   input  wire logic [4:0]      i_term,
   input  wire logic [4:0][5:0] i_input_terminal_function,
   input  wire logic            i_permit_follows_input,
   input  wire logic [1:0]      i_stop_action,
   input  wire logic [12:0]     i_qstop_time,
   input  wire logic [12:0]     i_acc_time,
   input  wire logic [12:0]     i_dec_time,
   input  wire logic [15:0]     i_ref_freq,
   input  wire logic [15:0]     i_start_freq,
   input  wire logic [15:0]     i_max_freq,
   input  wire logic [15:0]     i_acc_dwell_freq,
   input  wire logic [6:0]      i_acc_dwell_time,
   input  wire logic [15:0]     i_dec_dwell_freq,
   input  wire logic [9:0]      i_dec_dwell_time,
   input  wire logic [1:0]      i_ctrl_mode,
   input  wire logic            i_ext_brake,
   output logic [15:0]          o_freq,
   output logic                 o_output_block,
   output logic                 o_running,
   output logic                 o_dwell_active,
   output logic                 o_permit
);
   drpd_pkg::drpd_top_st_t s_q;
   drpd_pkg::drpd_top_st_t s_d;

   logic        tick_ms;
   logic        tick_dwell;
   logic [15:0] ramp_freq;
   logic        ramp_at;
   logic [15:0] ramp_target;
   logic [12:0] ramp_down;
   logic        ramp_clear;

   ////////////////////////////////////////////////////////////////////////////////
   // time bases

   drpd_tick_div #(.DIV(MS_CYCLES)) u_ms_div (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_en    (1'b1),
      .o_tick  (tick_ms)
   );

   // dwell counts free-running ticks, so a dwell may end up to one tick early
   drpd_tick_div #(.DIV(`DRPD_DWELL_TICK_MS)) u_dwell_div (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_en    (tick_ms),
      .o_tick  (tick_dwell)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // run permit

   logic [4:0] permit_sel;
   logic       permit_now;

   always_comb begin
      // any one assigned permit terminal that is on grants the run
      for (int i = 0; i < 5; i++) begin
         permit_sel[i] = (i_input_terminal_function[i] == `DRPD_FUNC_RUN_PERMIT);
      end
      if (i_permit_follows_input == `DRPD_PERMIT_ALWAYS) begin
         permit_now = 1'b1;
      end else if (permit_sel == 5'h00) begin
         permit_now = 1'b1;
      end else begin
         permit_now = |(permit_sel & i_term);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // settings, clamped to their ranges

   function automatic logic [15:0] drpd_clamp(input logic [15:0] f,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
      drpd_clamp = (f < lo) ? lo : ((f > hi) ? hi : f);
   endfunction

   logic [1:0]  action;
   logic [12:0] qstop_t;
   logic [9:0]  acc_dw_t;
   logic [9:0]  dec_dw_t;
   logic [15:0] acc_dw_f;
   logic [15:0] dec_dw_f;
   logic [15:0] ref_f;
   logic        dwell_mode;
   logic        acc_dw_en;
   logic        dec_dw_en;

   always_comb begin
      // out-of-range codes fall back to the coast default
      if (i_stop_action > `DRPD_ACT_QRESUME) begin
         action = `DRPD_ACT_COAST;
      end else begin
         action = i_stop_action;
      end
      if (i_qstop_time > `DRPD_QSTOP_MAX) begin
         qstop_t = `DRPD_QSTOP_MAX;
      end else begin
         qstop_t = i_qstop_time;
      end
      if (i_acc_dwell_time > `DRPD_ACC_DWELL_MAX) begin
         acc_dw_t = {3'h0, `DRPD_ACC_DWELL_MAX};
      end else begin
         acc_dw_t = {3'h0, i_acc_dwell_time};
      end
      if (i_dec_dwell_time > `DRPD_DEC_DWELL_MAX) begin
         dec_dw_t = `DRPD_DEC_DWELL_MAX;
      end else begin
         dec_dw_t = i_dec_dwell_time;
      end
      acc_dw_f = drpd_clamp(i_acc_dwell_freq, i_start_freq, i_max_freq);
      dec_dw_f = drpd_clamp(i_dec_dwell_freq, i_start_freq, i_max_freq);
      ref_f    = drpd_clamp(i_ref_freq, `DRPD_FREQ_ZERO, i_max_freq);
      dwell_mode = (i_ctrl_mode == `DRPD_CTRL_VF);
      acc_dw_en  = dwell_mode && (acc_dw_t != 10'h000) &&
                   (i_acc_dwell_freq != `DRPD_FREQ_ZERO);
      dec_dw_en  = dwell_mode && !i_ext_brake && (dec_dw_t != 10'h000) &&
                   (i_dec_dwell_freq != `DRPD_FREQ_ZERO);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // run sequencer

   logic run_rise;
   logic permit_fall;
   logic running;

   always_comb begin
      s_d         = s_q;
      s_d.run     = i_run_cmd;
      s_d.permit  = permit_now;
      run_rise    = i_run_cmd && !s_q.run;
      running     = (s_q.st != drpd_pkg::DRPD_IDLE);
      permit_fall = s_q.permit && !permit_now && running;
      ramp_target = `DRPD_FREQ_ZERO;
      ramp_down   = i_dec_time;
      ramp_clear  = 1'b0;

      // ramp_at compares against the target picked below, so it holds in the same cycle
      unique case (s_q.st)
         drpd_pkg::DRPD_IDLE: begin
            // output stays blocked until a start is accepted
            s_d.block = 1'b1;
            ramp_clear = 1'b1;
            if (i_run_cmd && permit_now && (run_rise || !s_q.need_edge)) begin
               s_d.st         = drpd_pkg::DRPD_ACC_RAMP;
               s_d.block      = 1'b0;
               s_d.need_edge  = 1'b0;
               s_d.dwell_pend = acc_dw_en;
            end
         end
         drpd_pkg::DRPD_ACC_RAMP: begin
            ramp_target = (s_q.dwell_pend && ref_f > acc_dw_f) ? acc_dw_f : ref_f;
            if (!i_run_cmd) begin
               s_d.st         = drpd_pkg::DRPD_DEC_RAMP;
               s_d.dwell_pend = dec_dw_en && (ramp_freq > dec_dw_f);
            end else if (ramp_at && s_q.dwell_pend && ref_f > acc_dw_f) begin
               s_d.st        = drpd_pkg::DRPD_ACC_DWELL;
               s_d.dwell_cnt = '0;
            end else if (ramp_at) begin
               s_d.st         = drpd_pkg::DRPD_RUN;
               s_d.dwell_pend = 1'b0;
            end
         end
         drpd_pkg::DRPD_ACC_DWELL: begin
            ramp_target = acc_dw_f;
            if (tick_dwell) begin
               s_d.dwell_cnt = s_q.dwell_cnt + 10'h001;
            end
            if (!i_run_cmd) begin
               s_d.st         = drpd_pkg::DRPD_DEC_RAMP;
               s_d.dwell_pend = 1'b0;
            end else if (s_q.dwell_cnt >= acc_dw_t) begin
               s_d.st         = drpd_pkg::DRPD_ACC_RAMP;
               s_d.dwell_pend = 1'b0;
            end
         end
         drpd_pkg::DRPD_RUN: begin
            // a lower reference ramps down here, never through a dwell
            ramp_target = ref_f;
            if (!i_run_cmd) begin
               s_d.st         = drpd_pkg::DRPD_DEC_RAMP;
               s_d.dwell_pend = dec_dw_en && (ramp_freq > dec_dw_f);
            end
         end
         drpd_pkg::DRPD_DEC_RAMP: begin
            ramp_target = s_q.dwell_pend ? dec_dw_f : `DRPD_FREQ_ZERO;
            if (i_run_cmd && permit_now) begin
               s_d.st         = drpd_pkg::DRPD_RUN;
               s_d.dwell_pend = 1'b0;
            end else if (ramp_at && s_q.dwell_pend) begin
               s_d.st        = drpd_pkg::DRPD_DEC_DWELL;
               s_d.dwell_cnt = '0;
            end else if (ramp_at) begin
               s_d.st = drpd_pkg::DRPD_IDLE;
               s_d.block = 1'b1;
            end
         end
         drpd_pkg::DRPD_DEC_DWELL: begin
            ramp_target = dec_dw_f;
            if (tick_dwell) begin
               s_d.dwell_cnt = s_q.dwell_cnt + 10'h001;
            end
            if (i_run_cmd && permit_now) begin
               s_d.st         = drpd_pkg::DRPD_RUN;
               s_d.dwell_pend = 1'b0;
            end else if (s_q.dwell_cnt >= dec_dw_t) begin
               s_d.st         = drpd_pkg::DRPD_DEC_RAMP;
               s_d.dwell_pend = 1'b0;
            end
         end
         drpd_pkg::DRPD_QSTOP: begin
            ramp_down = qstop_t;
            if (ramp_at) begin
               s_d.st = drpd_pkg::DRPD_IDLE;
               s_d.block = 1'b1;
            end
         end
         default: begin
            s_d.st = drpd_pkg::DRPD_IDLE;
         end
      endcase

      // losing the permit overrides every running state
      if (permit_fall) begin
         s_d.dwell_pend = 1'b0;
         if (action == `DRPD_ACT_COAST) begin
            s_d.st        = drpd_pkg::DRPD_IDLE;
            s_d.block     = 1'b1;
            s_d.need_edge = 1'b1;
            ramp_clear    = 1'b1;
         end else begin
            s_d.st        = drpd_pkg::DRPD_QSTOP;
            s_d.need_edge = (action == `DRPD_ACT_QSTOP);
            ramp_target   = `DRPD_FREQ_ZERO;
            ramp_down     = qstop_t;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q            <= '0;
         s_q.st         <= drpd_pkg::DRPD_IDLE;
         s_q.block      <= 1'b1;
         // the first start after reset needs a fresh run edge
         s_q.need_edge  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frequency ramp

   // a zero ramp time jumps straight to the target in one clock
   drpd_ramp u_ramp (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_tick_ms   (tick_ms),
      .i_clear     (ramp_clear),
      .i_target    (ramp_target),
      .i_up_time   (i_acc_time),
      .i_down_time (ramp_down),
      .i_max_freq  (i_max_freq),
      .o_freq      (ramp_freq),
      .o_at_target (ramp_at)
   );

   assign o_freq         = ramp_freq;
   // block is registered so it never glitches while the state decodes
   assign o_output_block = s_q.block;
   assign o_running      = (s_q.st != drpd_pkg::DRPD_IDLE);
   assign o_dwell_active = (s_q.st == drpd_pkg::DRPD_ACC_DWELL) ||
                           (s_q.st == drpd_pkg::DRPD_DEC_DWELL);
   assign o_permit       = s_q.permit;
endmodule // drpd_top

// >>> logic/drpd_consts.svh
`ifndef DRPD_CONSTS_SVH
`define DRPD_CONSTS_SVH

// timing
`define DRPD_CLK_PERIOD_NS   4
`define DRPD_MS_TICK_NS      1000000
`define DRPD_DWELL_TICK_MS   100
`define DRPD_MS_PER_TENTH    20'h0_0064

// terminal function and selector codes
`define DRPD_FUNC_RUN_PERMIT 6'h0d
`define DRPD_PERMIT_ALWAYS   1'h0
`define DRPD_PERMIT_FOLLOWS  1'h1
`define DRPD_ACT_COAST       2'h0
`define DRPD_ACT_QSTOP       2'h1
`define DRPD_ACT_QRESUME     2'h2
`define DRPD_CTRL_VF         2'h0

// setting limits, tenths of a second
`define DRPD_QSTOP_MAX       13'h1770
`define DRPD_ACC_DWELL_MAX   7'h64
`define DRPD_DEC_DWELL_MAX   10'h258

// documented defaults of the settings, for the party that drives them
`define DRPD_DEF_PERMIT_MODE 1'h1
`define DRPD_DEF_STOP_ACT    2'h0
`define DRPD_DEF_QSTOP_TIME  13'h0032
`define DRPD_DEF_DWELL_FREQ  16'h01f4
`define DRPD_DEF_DWELL_TIME  7'h00

`define DRPD_FREQ_ZERO       16'h0000

`endif

// >>> logic/drpd_pkg.sv
package drpd_pkg;

   typedef enum logic [2:0] {
      DRPD_IDLE      = 3'b000,
      DRPD_ACC_RAMP  = 3'b001,
      DRPD_ACC_DWELL = 3'b010,
      DRPD_RUN       = 3'b011,
      DRPD_DEC_RAMP  = 3'b100,
      DRPD_DEC_DWELL = 3'b101,
      DRPD_QSTOP     = 3'b110
   } drpd_state_t;

   typedef struct packed {
      drpd_state_t st;
      logic        run;
      logic        permit;
      logic        need_edge;
      logic        dwell_pend;
      logic        block;
      logic [9:0]  dwell_cnt;
   } drpd_top_st_t;

   typedef struct packed {
      logic [15:0] freq;
      logic [23:0] acc;
   } drpd_ramp_st_t;

endpackage

// >>> logic/drpd_tick_div.sv
`timescale 1ns/100ps
module drpd_tick_div #(
   parameter int DIV = 2
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_en,
   output logic      o_tick
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
   } drpd_div_st_t;

   drpd_div_st_t s_q;
   drpd_div_st_t s_d;

   always_comb begin
      s_d = s_q;
      if (i_en) begin
         s_d.cnt = (s_q.cnt == LAST) ? '0 : s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_tick = i_en && (s_q.cnt == LAST);
endmodule // drpd_tick_div

// >>> logic/drpd_ramp.sv
`timescale 1ns/100ps
`include "drpd_consts.svh"
// linear frequency ramp: a time setting is the time for a swing of the full maximum frequency
module drpd_ramp (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_tick_ms,
   input  wire logic        i_clear,
   input  wire logic [15:0] i_target,
   input  wire logic [12:0] i_up_time,
   input  wire logic [12:0] i_down_time,
   input  wire logic [15:0] i_max_freq,
   output logic [15:0]      o_freq,
   output logic             o_at_target
);
   drpd_pkg::drpd_ramp_st_t s_q;
   drpd_pkg::drpd_ramp_st_t s_d;

   logic        up;
   logic [19:0] span_ms;
   logic [23:0] acc_n;

   always_comb begin
      s_d     = s_q;
      up      = i_target > s_q.freq;
      span_ms = 20'(up ? i_up_time : i_down_time) * `DRPD_MS_PER_TENTH;
      acc_n   = s_q.acc + (i_tick_ms ? {8'h00, i_max_freq} : 24'h00_0000);
      if (i_clear) begin
         s_d = '0;
      end else if (s_q.freq == i_target) begin
         s_d.acc = '0;
      end else if (span_ms == 20'h0_0000) begin
         s_d.freq = i_target;
         s_d.acc  = '0;
      end else if (acc_n >= {4'h0, span_ms}) begin
         // one step a clock is far faster than any settable slope needs
         s_d.acc  = acc_n - {4'h0, span_ms};
         s_d.freq = up ? s_q.freq + 16'h0001 : s_q.freq - 16'h0001;
      end else begin
         s_d.acc = acc_n;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_freq      = s_q.freq;
   assign o_at_target = (s_q.freq == i_target);
endmodule // drpd_ramp

// >>> verification/drpd_chk.sv
`timescale 1ns/100ps
`include "drpd_consts.svh"
module drpd_chk (
   input wire logic            i_clk,
   input wire logic            i_rst_n,
   input wire logic            i_run_cmd,
   input wire logic [4:0]      i_term,
   input wire logic [4:0][5:0] i_input_terminal_function,
   input wire logic            i_permit_follows_input,
   input wire logic [1:0]      i_stop_action,
   input wire logic [12:0]     i_qstop_time,
   input wire logic [15:0]     i_acc_dwell_freq,
   input wire logic [6:0]      i_acc_dwell_time,
   input wire logic [15:0]     i_dec_dwell_freq,
   input wire logic [9:0]      i_dec_dwell_time,
   input wire logic [1:0]      i_ctrl_mode,
   input wire logic            i_ext_brake,
   input wire logic [15:0]     o_freq,
   input wire logic            o_output_block,
   input wire logic            o_running,
   input wire logic            o_dwell_active,
   input wire logic            o_permit
);
   logic perm_c;
   logic loss;
   logic no_dw;
   always_comb begin
      logic any;
      any = 1'b0;
      perm_c = 1'b0;
      for (int k = 0; k < 5; k++) begin
         if (i_input_terminal_function[k] == `DRPD_FUNC_RUN_PERMIT) begin
            any = 1'b1;
            perm_c = perm_c | i_term[k];
         end
      end
      if (!any || !i_permit_follows_input) begin
         perm_c = 1'b1;
      end
   end
   assign loss = o_running & o_permit & ~perm_c;
   assign no_dw = (i_acc_dwell_time == 7'h00 || i_acc_dwell_freq == 16'h0000)
                  && (i_dec_dwell_time == 10'h000 || i_dec_dwell_freq == 16'h0000);
   ////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_coasted;
      !o_running ##1 (o_output_block && o_freq == 16'h0000);
   endsequence
   sequence s_fresh_run;
      $past(i_run_cmd) && !$past(i_run_cmd, 2);
   endsequence
   AST_COAST_STOP: assert property (
      loss && i_stop_action == `DRPD_ACT_COAST |=> s_coasted) else $error("coast not applied");
   AST_QSTOP_RAMP: assert property (
      loss && i_stop_action != `DRPD_ACT_COAST && i_stop_action != 2'h3
      && i_qstop_time != 13'h0000 && o_freq > 16'h0010 |=> o_running [*2])
      else $error("quick stop did not ramp");
   AST_NO_PERMIT: assert property (
      !o_running && !perm_c && !o_permit |=> !o_running) else $error("run without permit");
   AST_ALWAYS_GRANT: assert property (
      !i_permit_follows_input |=> o_permit) else $error("permit not granted");
   AST_EDGE_START: assert property (
      $rose(o_running) && i_stop_action != `DRPD_ACT_QRESUME |-> s_fresh_run)
      else $error("start without run edge");
   AST_START_OUT: assert property (
      $rose(o_running) |-> !o_output_block) else $error("output blocked at start");
   AST_DWELL_FREQ: assert property (
      $rose(o_dwell_active) |-> o_freq == i_acc_dwell_freq || o_freq == i_dec_dwell_freq)
      else $error("dwell at wrong frequency");
   AST_DWELL_HOLD: assert property (
      o_dwell_active && $past(o_dwell_active) |-> $stable(o_freq)) else $error("dwell moved");
   AST_ZERO_SKIP: assert property (
      no_dw [*2] |-> !o_dwell_active) else $error("dwell with zero setting");
   AST_MODE_GATE: assert property (
      (i_ctrl_mode != `DRPD_CTRL_VF) [*2] |-> !o_dwell_active) else $error("dwell not in vf");
   AST_BRAKE: assert property (
      (i_ext_brake && i_acc_dwell_time == 7'h00) [*2] |-> !o_dwell_active)
      else $error("dwell under brake");
endmodule // drpd_chk
bind drpd_top drpd_chk u_drpd_chk (.*);

// >>> verification/drpd_opr_model.sv
`timescale 1ns/100ps
module drpd_opr_model (
   input  wire logic       i_clk,
   input  wire logic       i_run_req,
   input  wire logic       i_permit_req,
   input  wire logic [2:0] i_slot,
   output logic            o_run_cmd = 1'b0,
   output logic [4:0]      o_term = 5'h00
);
   // unassigned terminals toggle every cycle so only the permit slot may matter
   // requests are sampled on the edge, so the bench's own updates never race them
   always @(posedge i_clk) begin
      o_run_cmd <= #1 i_run_req;
      o_term    <= #1 (~o_term & ~(5'h01 << i_slot)) | (5'(i_permit_req) << i_slot);
   end
endmodule // drpd_opr_model

// >>> verification/drpd_top_test.sv
`timescale 1ns/100ps
`include "drpd_consts.svh"
module drpd_top_test;
   logic clk = 1'b0, rst_n = 1'b0, run_req = 1'b0, perm_req = 1'b0, follows = 1'b1, ext = 1'b0;
   logic [2:0] slot = 3'h0;
   logic [4:0][5:0] func = '0;
   logic [1:0] act = 2'h0, mode = 2'h0;
   logic [15:0] rf = 16'h0300, dw_a = 16'h0100, dw_d = 16'h0080;
   logic [6:0] ta = 7'h02;
   logic [9:0] td = 10'h001;
   logic [12:0] qt = 13'h0001;
   logic run_cmd, blk, runn, dwl, perm;
   logic [4:0] term;
   logic [15:0] frq;
   logic [20:0] e, exp_q[$];
   int error_cnt = 0, checked = 0;
   event snap;
   always #2 clk = ~clk;
   drpd_opr_model u_opr (.i_clk(clk), .i_run_req(run_req), .i_permit_req(perm_req),
      .i_slot(slot), .o_run_cmd(run_cmd), .o_term(term));
   drpd_top #(.MS_CYCLES(10)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_run_cmd(run_cmd),
      .i_term(term), .i_input_terminal_function(func), .i_permit_follows_input(follows),
      .i_stop_action(act), .i_qstop_time(qt), .i_acc_time(13'h0000),
      .i_dec_time(13'h0000), .i_ref_freq(rf), .i_start_freq(16'h0064),
      .i_max_freq(16'h0400), .i_acc_dwell_freq(dw_a), .i_acc_dwell_time(ta),
      .i_dec_dwell_freq(dw_d), .i_dec_dwell_time(td), .i_ctrl_mode(mode),
      .i_ext_brake(ext), .o_freq(frq), .o_output_block(blk), .o_running(runn),
      .o_dwell_active(dwl), .o_permit(perm));
   ////////////////////////////////////////
   task automatic chk(input logic [20:0] seen, input logic [20:0] expv);
      checked++;
      if (seen !== expv) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   // flags are {block, running, dwell, permit}; freq compared only when use_f is set
   task automatic note(input logic [3:0] fl, input logic use_f, input logic [15:0] f);
      exp_q.push_back({use_f, f, fl});
      ->snap;
   endtask
   always @(snap) begin
      e = exp_q.pop_front();
      chk({e[20], e[20] ? frq : 16'h0000, blk, runn, dwl, perm}, e);
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // 0: stopped, 1: dwelling, 2: not dwelling, 3: at reference
   task automatic wait_on(input int sel, input int lim);
      int n;
      n = 0;
      while (n < lim && !((sel == 0 && runn === 1'b0) || (sel == 1 && dwl === 1'b1)
             || (sel == 2 && dwl === 1'b0) || (sel == 3 && frq === rf))) begin
         cyc(1);
         n++;
      end
      if (n >= lim) begin
         error_cnt++;
         $display("BAD t=%0t wait limit reached", $time);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #(4 * 90000);
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////
   initial begin
      void'($urandom(6));
      slot = 3'($urandom % 5);
      func[slot] = `DRPD_FUNC_RUN_PERMIT;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      cyc(2);
      note(4'b1000, 1'b1, 16'h0000);
      run_req = 1'b1;
      cyc(20);
      note(4'b1000, 1'b1, 16'h0000);
      run_req = 1'b0;
      follows = 1'b0;
      cyc(4);
      note(4'b1001, 1'b1, 16'h0000);
      follows = 1'b1;
      perm_req = 1'b1;
      cyc(4);
      $display("permit gating done");
      run_req = 1'b1;
      wait_on(1, 5000);
      note(4'b0111, 1'b1, dw_a);
      wait_on(2, 5000);
      wait_on(3, 5000);
      note(4'b0101, 1'b1, rf);
      run_req = 1'b0;
      wait_on(1, 5000);
      note(4'b0111, 1'b1, dw_d);
      wait_on(0, 5000);
      note(4'b1001, 1'b1, 16'h0000);
      $display("dwell profile done");
      ta = 7'h00;
      td = 10'h000;
      run_req = 1'b1;
      wait_on(3, 5000);
      note(4'b0101, 1'b1, rf);
      perm_req = 1'b0;
      cyc(4);
      note(4'b1000, 1'b1, 16'h0000);
      perm_req = 1'b1;
      cyc(50);
      note(4'b1001, 1'b1, 16'h0000);
      run_req = 1'b0;
      cyc(4);
      $display("coast done");
      for (int a = 1; a < 3; a++) begin
         qt = 13'(a);
         act = 2'(a);
         run_req = 1'b1;
         wait_on(3, 5000);
         perm_req = 1'b0;
         cyc(50);
         note(4'b0100, 1'b0, 16'h0000);
         wait_on(0, 20000);
         note(4'b1000, 1'b1, 16'h0000);
         perm_req = 1'b1;
         cyc(50);
         note(a == 2 ? 4'b0101 : 4'b1001, 1'b0, 16'h0000);
         run_req = 1'b0;
         wait_on(0, 20000);
         cyc(4);
      end
      act = 2'h0;
      $display("quick stop done");
      mode = 2'(1 + $urandom % 3);
      ta = 7'h02;
      td = 10'h001;
      rf = 16'(16'h0065 + $urandom % 16'h039b);
      run_req = 1'b1;
      wait_on(3, 5000);
      note(4'b0101, 1'b1, rf);
      run_req = 1'b0;
      wait_on(0, 5000);
      mode = 2'h0;
      ext = 1'b1;
      ta = 7'h00;
      rf = 16'h0300;
      cyc(4);
      run_req = 1'b1;
      wait_on(3, 5000);
      run_req = 1'b0;
      wait_on(0, 5000);
      note(4'b1001, 1'b1, 16'h0000);
      ext = 1'b0;
      $display("mode and brake done");
      end_of_test();
   end
endmodule // drpd_top_test
